// ===== common/spi_master_pkg.sv
package spi_master_pkg;
   localparam int CLEN_W = 5;                 // char length minus one, 0..31
   localparam int FLEN_W = 12;                // frame length minus one, 0..4095
   localparam int DIV_W = 16;                 // half-period divider width
   localparam int DLY_W = 2;                  // cs-to-data delay, 0..3 clocks
   localparam int NCS = 4;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
   localparam logic [CLEN_W:0] BITCNT_RESET = 6'h00;
   localparam logic [FLEN_W:0] CHRCNT_RESET = 13'h0000;
   localparam int SYNC_STAGES = 3;

   // per-select link options
   typedef struct packed {
      logic clock_polarity_sel;
      logic clock_phase_sel;
      logic cs_active_high;
   } cs_cfg_t;

   // one transfer command
   typedef struct packed {
      logic [1:0] cs_num;
      logic [CLEN_W-1:0] char_len_m1;
      logic [FLEN_W-1:0] frame_len_m1;
      logic [DLY_W-1:0] data_delay;
      logic loopback;
      logic irq_enable;
   } cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SELECT = 3'b001,
      ST_LEAD = 3'b010,
      ST_TRAIL = 3'b011,
      ST_DONE = 3'b100
   } state_t;
endpackage : spi_master_pkg

// ===== core/serial_peripheral_master_port.sv
`timescale 1ns/100ps
module serial_peripheral_master_port (
   // system
   input wire logic clock,
   input wire logic rst,
   // configuration
   input wire logic [spi_master_pkg::DIV_W-1:0] clock_divider,
   input wire spi_master_pkg::cs_cfg_t [spi_master_pkg::NCS-1:0] cs_config,
   // command and data
   input wire logic cmd_start,
   input wire spi_master_pkg::cmd_t cmd,
   input wire logic [31:0] tx_data,
   output logic tx_data_taken,
   output logic [31:0] rx_data,
   output logic rx_valid,
   // status
   output logic busy,
   output logic char_irq,
   // serial link
   output logic serial_clock_out,
   output logic [spi_master_pkg::NCS-1:0] slave_select_out,
   output logic serial_tx_out,
   input wire logic serial_rx_in
);
   import spi_master_pkg::*;

   state_t state_reg;
   cmd_t cmd_reg;
   logic [DIV_W-1:0] div_cnt_reg;
   logic [CLEN_W:0] bit_cnt_reg;
   logic [FLEN_W:0] chr_cnt_reg;
   logic [DLY_W-1:0] dly_cnt_reg;
   logic [31:0] tx_shift_reg;
   logic [31:0] rx_shift_reg;
   logic [SYNC_STAGES-1:0] rx_sync_reg;
   logic rx_level_reg;
   logic tick;
   logic cpol;
   logic cpha;
   logic rx_bit;
   logic last_bit;
   logic last_char;
   logic [NCS-1:0] sel_onehot;
   // decoded shift strobes, shared so the shift processes cannot disagree
   logic load_first;
   logic present_first;
   logic lead_edge;
   logic trail_edge;
   logic drive_edge;
   logic sample_edge;
   logic char_end;

   // stretch a frame-level index to a one-hot select vector
   function automatic logic [NCS-1:0] onehot(input logic [1:0] n);
      onehot = 4'h1 << n;
   endfunction : onehot

   // left-align a right-justified character so its msb sits in bit 31
   // the bits above the programmed length fall off the top and are never sent
   function automatic logic [31:0] align_char(input logic [31:0] data,
                                              input logic [CLEN_W-1:0] len_m1);
      align_char = data << (6'd31 - {1'b0, len_m1});
   endfunction : align_char

   assign cpol = cs_config[cmd_reg.cs_num].clock_polarity_sel;
   assign cpha = cs_config[cmd_reg.cs_num].clock_phase_sel;
   assign last_bit = (bit_cnt_reg == {1'b0, cmd_reg.char_len_m1});
   assign last_char = (chr_cnt_reg == {1'b0, cmd_reg.frame_len_m1});
   // loopback bypasses the pin so a board fault cannot mask a core fault
   assign rx_bit = cmd_reg.loopback ? serial_tx_out : rx_level_reg;

   // receive pin synchroniser; only the settled stages are compared
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_sync_reg <= '0;
         rx_level_reg <= 1'b0;
      end else begin
         rx_sync_reg <= {rx_sync_reg[SYNC_STAGES-2:0], serial_rx_in};
         if (rx_sync_reg[1] == rx_sync_reg[2]) begin
            rx_level_reg <= rx_sync_reg[2];
         end
      end
   end

   // half-period divider: one tick per serial clock edge
   always_ff @(posedge clock) begin
      if (rst || state_reg == ST_IDLE || tick) begin
         div_cnt_reg <= DIV_RESET;
      end else begin
         div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
   end
   assign tick = (div_cnt_reg >= clock_divider);

   // transfer sequencer
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cmd_reg <= '0;
         bit_cnt_reg <= BITCNT_RESET;
         chr_cnt_reg <= CHRCNT_RESET;
         dly_cnt_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (cmd_start) begin
                  cmd_reg <= cmd;
                  bit_cnt_reg <= BITCNT_RESET;
                  chr_cnt_reg <= CHRCNT_RESET;
                  dly_cnt_reg <= cmd.data_delay;
                  state_reg <= ST_SELECT;
               end
            end
            ST_SELECT: begin
               // a full serial clock period per delay step
               if (tick) begin
                  if (dly_cnt_reg == 2'h0) begin
                     state_reg <= ST_LEAD;
                  end else begin
                     dly_cnt_reg <= dly_cnt_reg - 2'h1;
                     state_reg <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               // second half of a delay step
               if (tick) begin
                  state_reg <= ST_SELECT;
               end
            end
            ST_LEAD: begin
               if (tick) begin
                  state_reg <= ST_TRAIL;
               end
            end
            ST_TRAIL: begin
               if (tick) begin
                  if (!last_bit) begin
                     bit_cnt_reg <= bit_cnt_reg + 6'h01;
                     state_reg <= ST_LEAD;
                  end else if (!last_char) begin
                     bit_cnt_reg <= BITCNT_RESET;
                     chr_cnt_reg <= chr_cnt_reg + 13'h0001;
                     state_reg <= ST_LEAD;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // serial clock: idle at polarity, toggles on each tick while shifting
   always_ff @(posedge clock) begin
      if (rst) begin
         serial_clock_out <= 1'b0;
      end else if (state_reg == ST_LEAD || state_reg == ST_TRAIL) begin
         if (tick) begin
            serial_clock_out <= (state_reg == ST_LEAD) ? ~cpol : cpol;
         end
      end else begin
         serial_clock_out <= cs_config[state_reg == ST_IDLE ? cmd.cs_num : cmd_reg.cs_num]
                             .clock_polarity_sel;
      end
   end

   // chip selects: only the addressed one asserts, for the whole frame
   assign sel_onehot = onehot(cmd_reg.cs_num);
   generate
      for (genvar i = 0; i < NCS; i++) begin : g_select
         // each pin keeps its own level, so an unused select follows only its own polarity
         always_ff @(posedge clock) begin
            if (rst) begin
               slave_select_out[i] <= 1'b1;
            end else begin
               slave_select_out[i] <= ((state_reg != ST_IDLE) && sel_onehot[i])
                                      ~^ cs_config[i].cs_active_high;
            end
         end
      end
   endgenerate

   // shift strobes: msb-first within the programmed length
   // phase 0 presents data before the lead edge, samples on lead, shifts on trail;
   // phase 1 shifts on the lead edge and samples on the trail edge
   assign load_first = (state_reg == ST_IDLE) && cmd_start;
   assign present_first = (state_reg == ST_SELECT) && tick && (dly_cnt_reg == 2'h0) && !cpha;
   assign lead_edge = tick && (state_reg == ST_LEAD);
   assign trail_edge = tick && (state_reg == ST_TRAIL);
   // the last trail edge of a character reloads instead of shifting
   assign drive_edge = cpha ? lead_edge : (trail_edge && !last_bit);
   assign sample_edge = cpha ? trail_edge : lead_edge;
   assign char_end = trail_edge && last_bit;

   // transmit shifter; software supplies each next character on the pins
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_shift_reg <= '0;
      end else if (load_first) begin
         tx_shift_reg <= align_char(tx_data, cmd.char_len_m1);
      end else if (char_end) begin
         if (!cpha && !last_char) begin
            // phase 0 puts the msb on the pin now, so the shifter starts one bit on
            tx_shift_reg <= align_char(tx_data, cmd_reg.char_len_m1) << 1;
         end else begin
            tx_shift_reg <= align_char(tx_data, cmd_reg.char_len_m1);
         end
      end else if (present_first || drive_edge) begin
         tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
      end
   end

   // transmit pin; it holds the last bit sent after a frame until the next start clears it
   always_ff @(posedge clock) begin
      if (rst) begin
         serial_tx_out <= 1'b0;
      end else if (load_first) begin
         serial_tx_out <= 1'b0;
      end else if (char_end) begin
         if (!cpha && !last_char) begin
            serial_tx_out <= tx_data[cmd_reg.char_len_m1];
         end
      end else if (present_first || drive_edge) begin
         serial_tx_out <= tx_shift_reg[31];
      end
   end

   // receive shifter; cleared per character so short characters come out
   // right-justified with zeros above them
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_shift_reg <= '0;
      end else if (load_first || char_end) begin
         rx_shift_reg <= '0;
      end else if (sample_edge) begin
         rx_shift_reg <= {rx_shift_reg[30:0], rx_bit};
      end
   end

   // handover pulses and the received character
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_data_taken <= 1'b0;
         rx_data <= '0;
         rx_valid <= 1'b0;
         char_irq <= 1'b0;
      end else begin
         tx_data_taken <= load_first || (char_end && !last_char);
         rx_valid <= char_end;
         char_irq <= char_end && cmd_reg.irq_enable;
         if (char_end) begin
            // phase 1 samples its last bit on this very edge
            rx_data <= cpha ? {rx_shift_reg[30:0], rx_bit} : rx_shift_reg;
         end
      end
   end

   // busy is registered; it rises with the sequencer leaving idle and falls one cycle after it returns
   always_ff @(posedge clock) begin
      if (rst) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_reg != ST_IDLE) || cmd_start;
      end
   end
endmodule : serial_peripheral_master_port

// ===== tb/spi_slave_model.sv
`timescale 1ns/100ps
// mode 0 slave answering one fixed word, msb first
module spi_slave_model #(
   parameter logic [31:0] PAT = 32'hC3A5_0F96
) (
   // serial link
   input wire logic sclk,
   input wire logic sel_n,
   output logic miso
);
   int idx = 31;
   // restart on select, step on each falling clock edge while selected
   always @(negedge sel_n) idx = 31;
   always @(negedge sclk) if (!sel_n) idx = idx - 1;
   // deselected it drives the inverse, so a stale bit never passes for data
   assign miso = sel_n ? ~PAT[idx[4:0]] : PAT[idx[4:0]];
endmodule : spi_slave_model

// ===== tb/serial_peripheral_master_port_monitor.sv
`timescale 1ns/100ps
module serial_peripheral_master_port_monitor (
   // system and control
   input wire logic clock,
   input wire logic rst,
   input wire logic [spi_master_pkg::DIV_W-1:0] clock_divider,
   input wire spi_master_pkg::cs_cfg_t [spi_master_pkg::NCS-1:0] cs_config,
   input wire logic cmd_start,
   input wire spi_master_pkg::cmd_t cmd,
   input wire logic [31:0] tx_data,
   input wire logic tx_data_taken,
   input wire logic [31:0] rx_data,
   input wire logic rx_valid,
   input wire logic busy,
   input wire logic char_irq,
   // serial link
   input wire logic serial_clock_out,
   input wire logic [spi_master_pkg::NCS-1:0] slave_select_out,
   input wire logic serial_tx_out,
   input wire logic serial_rx_in
);
   import spi_master_pkg::*;
   logic [NCS-1:0] act;
   logic pol, sck_q;
   logic [16:0] gap_q;
   logic [5:0] nbit_q;
   logic [12:0] nchr_q;
   logic [CLEN_W-1:0] len_q;
   logic [FLEN_W-1:0] fl_q;
   wire tog = serial_clock_out != sck_q;
   wire go = cmd_start && !busy;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // asserted select and the idle clock level it asks for
   always_comb begin
      pol = 1'b0;
      for (int i = 0; i < NCS; i++) begin
         act[i] = slave_select_out[i] == cs_config[i].cs_active_high;
         if (act[i]) pol = cs_config[i].clock_polarity_sel;
      end
   end
   // edge spacing plus bit and character counts of the running frame
   always_ff @(posedge clock) begin
      sck_q <= serial_clock_out;
      gap_q <= tog ? 17'h00001 : gap_q + 17'h00001;
      if (go) len_q <= cmd.char_len_m1;
      if (go) fl_q <= cmd.frame_len_m1;
      nchr_q <= go ? 13'h0000 : nchr_q + 13'(rx_valid);
      if (go || rx_valid) nbit_q <= 6'h00;
      else if (busy && act != '0 && tog && serial_clock_out != pol) nbit_q <= nbit_q + 6'h01;
   end
   chk_start_taken: assert property (
      go |=> busy && tx_data_taken) else $error("start not taken");
   chk_select_at_start: assert property (
      $rose(busy) |=> $onehot(act)) else $error("no single select");
   chk_select_held: assert property (
      busy && $onehot(act) && !rx_valid |=> $onehot(act)) else $error("select dropped");
   chk_taken_in_frame: assert property (
      tx_data_taken |-> busy) else $error("load outside frame");
   chk_irq_with_char: assert property (
      char_irq |-> rx_valid) else $error("stray irq");
   chk_half_period: assert property (
      busy && $past(busy) && tog && serial_clock_out == pol |->
      gap_q == 17'(clock_divider) + 17'h00001)
      else $error("half period wrong");
   chk_char_bits: assert property (
      rx_valid |-> nbit_q == 6'(len_q) + 6'h01) else $error("bit count wrong");
   chk_frame_chars: assert property (
      $fell(busy) |-> nchr_q == 13'(fl_q) + 13'h0001) else $error("char count wrong");
endmodule : serial_peripheral_master_port_monitor
bind serial_peripheral_master_port serial_peripheral_master_port_monitor i_monitor (.clock,
   .rst, .clock_divider, .cs_config, .cmd_start, .cmd, .tx_data, .tx_data_taken, .rx_data,
   .rx_valid, .busy, .char_irq, .serial_clock_out, .slave_select_out, .serial_tx_out,
   .serial_rx_in);

// ===== tb/serial_peripheral_master_port_tb.sv
`timescale 1ns/100ps
module serial_peripheral_master_port_tb;
   import spi_master_pkg::*;
   localparam logic [31:0] PAT = 32'hC3A5_0F96;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cmd_start = 1'b0;
   logic [DIV_W-1:0] clock_divider = 16'h0004;
   cs_cfg_t [NCS-1:0] cs_config = '0;
   cmd_t cmd = '0;
   logic [31:0] tx_data = 32'h0000_0000;
   logic [31:0] rx_data;
   logic [NCS-1:0] slave_select_out;
   logic tx_data_taken, rx_valid, busy, char_irq, serial_clock_out, serial_tx_out, serial_rx_in;
   logic [31:0] exp_q[$];
   int failures = 0, num_checks = 0, seed = 20, cycles = 0, irqs = 0;
   // 250 MHz system clock
   initial forever #2 clock = ~clock;
   serial_peripheral_master_port i_dut (.clock, .rst, .clock_divider, .cs_config, .cmd_start,
      .cmd, .tx_data, .tx_data_taken, .rx_data, .rx_valid, .busy, .char_irq,
      .serial_clock_out, .slave_select_out, .serial_tx_out, .serial_rx_in);
   spi_slave_model #(.PAT(PAT)) i_slave (.sclk(serial_clock_out),
      .sel_n(slave_select_out[0]), .miso(serial_rx_in));
   task automatic check(input logic [31:0] e, input logic [31:0] a);
      num_checks++;
      if (a !== e) begin
         failures++;
         $display("unexpected at %0t: expected %h got %h", $time, e, a);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   // one frame; start is held one extra edge while busy so it must be ignored
   task automatic frame(input logic [1:0] cs, input int len, input int nch, input logic lb,
      input logic irq, input logic [1:0] dly);
      logic [31:0] d[5];
      logic [31:0] mask;
      int t;
      mask = (len == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << len) - 32'h0000_0001;
      foreach (d[k]) d[k] = $random(seed);
      for (int k = 0; k < nch; k++) exp_q.push_back(lb ? d[k] & mask : PAT);
      irqs = 0;
      cmd = '{cs, 5'(len - 1), 12'(nch - 1), dly, lb, irq};
      tx_data = d[0];
      cmd_start = 1'b1;
      t = 0;
      // next character is presented once the previous one was loaded
      for (int k = 1; k <= nch; k++) begin
         do begin
            @(negedge clock);
            t++;
            cmd_start = (t == 1);
         end while (tx_data_taken !== 1'b1 && t < 9000);
         tx_data = d[k];
      end
      do begin
         @(negedge clock);
         cmd_start = 1'b0;
         t++;
      end while (busy !== 1'b0 && t < 9000);
   endtask : frame
   // watcher: each received character retires the oldest note
   always @(negedge clock) begin
      cycles++;
      if (char_irq === 1'b1) irqs++;
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) check(~rx_data, rx_data);
         else check(exp_q.pop_front(), rx_data);
      end
      if (cycles == 30000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      repeat (20) @(negedge clock);
      rst = 1'b0;
      // every select and all four clock modes through the internal loop
      for (int i = 0; i < 8; i++) begin
         cs_config = 12'($random(seed));
         cs_config[i % 4].clock_polarity_sel = i[2];
         cs_config[i % 4].clock_phase_sel = i[0];
         clock_divider = 16'h0004 + 16'($random(seed) & 3);
         frame(2'(i), (i == 0) ? 1 : (i == 1) ? 32 : 1 + ($random(seed) & 31), 1 + i % 3, 1'b1,
            i[1], 2'(i));
         check(i[1] ? 32'(1 + i % 3) : 32'h0000_0000, 32'(irqs));
         $display("loop test %0d done", i);
      end
      // external slave on select zero, mode 0, active low
      cs_config[0] = '0;
      frame(2'h0, 32, 1, 1'b0, 1'b1, 2'h1);
      $display("slave test done");
      end_of_test();
   end
endmodule : serial_peripheral_master_port_tb
